// >>> hdl/tcr_timer.sv
// 16-bit capture/restart timer with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"
module tcr_timer (
    input wire logic REF_CLK, // 200 MHz system clock
    input wire logic RST, // Asynchronous reset, high
    input wire logic CE, // Clock enable, freezes all state
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB write
    input wire tcr_pkg::tcr_addr_t PADDR, // APB byte address
    input wire tcr_pkg::tcr_data_t PWDATA, // APB write data
    output tcr_pkg::tcr_data_t PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error, unmapped address
    input wire logic TIMER_IN, // Timer input pin
    input wire logic CMP_IN, // Comparator output
    output logic TOUT, // Timer output pin
    output logic TOUT_OE, // Timer output pin enable
    output logic IRQ // Timer interrupt, level
);
    import tcr_pkg::*;

    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    tcr_word_t count_r;
    tcr_word_t count_nxt;
    tcr_word_t reload_r;
    tcr_word_t capture_r;
    logic [1:0] irq_st_r;
    logic [1:0] irq_mask_r;
    logic [1:0] glb_r;
    logic out_r;
    tcr_data_t prdata_r;
    logic pslverr_r;
    logic [2:0] in_sync_r;
    logic [2:0] cmp_sync_r;
    logic in_lvl_r;
    logic cmp_lvl_r;

    tcr_mode_t mode;
    logic en;
    logic pol;
    logic cap_mode;
    logic in_edge;
    logic cmp_edge;
    logic step;
    logic at_reload;
    logic cap_ev;
    logic rel_ev;
    logic cap_irq;
    logic rel_irq;
    logic [1:0] isrc;
    logic setup;
    logic wr;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_count;
    logic wr_reload;
    logic wr_capture;
    logic wr_status;
    logic wr_mask;
    logic wr_global;

    tcr_tick_if tk ();

    tcr_prescaler u_pre (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .tk(tk.pre)
    );

    // Selected edge, seen once stage two and stage three agree
    function automatic logic edge_hit(input logic s2, input logic s3,
                                      input logic lvl, input logic fall);
        return (s2 == s3) && (s3 != lvl) && (s3 == !fall);
    endfunction : edge_hit

    function automatic logic addr_is(input tcr_addr_t a,
                                     input tcr_addr_t ofs);
        return a == ofs;
    endfunction : addr_is

    function automatic logic addr_known(input tcr_addr_t a);
        return addr_is(a, `TCR_OFS_CTRL0) || addr_is(a, `TCR_OFS_CTRL1) ||
            addr_is(a, `TCR_OFS_COUNT) || addr_is(a, `TCR_OFS_RELOAD) ||
            addr_is(a, `TCR_OFS_CAPTURE) ||
            addr_is(a, `TCR_OFS_IRQ_STATUS) ||
            addr_is(a, `TCR_OFS_IRQ_MASK) || addr_is(a, `TCR_OFS_GLOBAL);
    endfunction : addr_known

    // Decoded control fields
    assign mode = tcr_mode_decode({ctrl0_r[`TCR_C0_MODE_HI],
        ctrl1_r[`TCR_C1_MODE_HI:`TCR_C1_MODE_LO]});
    assign en = ctrl1_r[`TCR_C1_EN];
    assign pol = ctrl1_r[`TCR_C1_POL];
    assign isrc = ctrl0_r[`TCR_C0_ISRC_HI:`TCR_C0_ISRC_LO];
    assign cap_mode = (mode == TCR_CAPTURE) || (mode == TCR_CAP_CMP) ||
        (mode == TCR_CAP_RESTART);

    assign tk.run = en;
    assign tk.sel = ctrl1_r[`TCR_C1_PRESCALE_SELECT_HI:`TCR_C1_PRESCALE_SELECT_LO];

    // APB decode: zero wait states unless the clock enable is low
    assign setup = PSEL && !PENABLE;
    assign wr = PSEL && PENABLE && PWRITE && CE;
    assign wr_ctrl0 = wr && addr_is(PADDR, `TCR_OFS_CTRL0);
    assign wr_ctrl1 = wr && addr_is(PADDR, `TCR_OFS_CTRL1);
    assign wr_count = wr && addr_is(PADDR, `TCR_OFS_COUNT);
    assign wr_reload = wr && addr_is(PADDR, `TCR_OFS_RELOAD);
    assign wr_capture = wr && addr_is(PADDR, `TCR_OFS_CAPTURE);
    assign wr_status = wr && addr_is(PADDR, `TCR_OFS_IRQ_STATUS);
    assign wr_mask = wr && addr_is(PADDR, `TCR_OFS_IRQ_MASK);
    assign wr_global = wr && addr_is(PADDR, `TCR_OFS_GLOBAL);

    assign PREADY = CE;
    assign PRDATA = prdata_r;
    assign PSLVERR = pslverr_r && PSEL && PENABLE;

    // Timer input pin synchroniser, three stages
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            in_sync_r <= 3'h0;
        end else if (CE) begin
            in_sync_r <= {in_sync_r[1:0], TIMER_IN};
        end
    end

    // Comparator pin synchroniser, three stages
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cmp_sync_r <= 3'h0;
        end else if (CE) begin
            cmp_sync_r <= {cmp_sync_r[1:0], CMP_IN};
        end
    end

    // Accepted levels, updated only when the last two stages agree
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            in_lvl_r <= 1'b0;
        end else if (CE && (in_sync_r[1] == in_sync_r[2])) begin
            in_lvl_r <= in_sync_r[2];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cmp_lvl_r <= 1'b0;
        end else if (CE && (cmp_sync_r[1] == cmp_sync_r[2])) begin
            cmp_lvl_r <= cmp_sync_r[2];
        end
    end

    assign in_edge = edge_hit(in_sync_r[1], in_sync_r[2], in_lvl_r,
        pol);
    assign cmp_edge = edge_hit(cmp_sync_r[1], cmp_sync_r[2], cmp_lvl_r,
        pol);

    // Count source per mode
    always_comb begin
        case (mode)
            TCR_COUNTER: step = en && in_edge;
            TCR_CMP_COUNTER: step = en && cmp_edge;
            TCR_GATED: step = en && tk.tick && (in_lvl_r == !pol);
            TCR_CAP_RESTART: step = en && tk.tick;
            default: step = en && tk.tick;
        endcase
    end

    assign at_reload = count_r == reload_r;
    assign cap_ev = en && cap_mode && in_edge;
    // A capture that restarts the count takes the place of a reload
    assign rel_ev = en && step && at_reload &&
        !(cap_ev && (mode == TCR_CAP_RESTART));

    // Interrupt source selection in capture modes
    assign cap_irq = cap_ev && (isrc != `TCR_ISRC_REL_ONLY);
    assign rel_irq = rel_ev &&
        (!cap_mode || (isrc != `TCR_ISRC_CAP_ONLY));

    // Next count: software load, restart, reload, or step
    always_comb begin
        if (wr_count) begin
            count_nxt = PWDATA[15:0];
        end else if (cap_ev && (mode == TCR_CAP_RESTART)) begin
            count_nxt = `TCR_RESTART;
        end else if (rel_ev) begin
            count_nxt = `TCR_RESTART;
        end else if (step) begin
            count_nxt = 16'(count_r + 16'h0001);
        end else begin
            count_nxt = count_r;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            count_r <= `TCR_RST_COUNT;
        end else if (CE) begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            reload_r <= `TCR_RST_RELOAD;
        end else if (CE && wr_reload) begin
            reload_r <= PWDATA[15:0];
        end
    end

    // Capture register; a capture in the same cycle beats a write
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            capture_r <= `TCR_RST_CAPTURE;
        end else if (CE) begin
            if (cap_ev) begin
                capture_r <= count_r;
            end else if (wr_capture) begin
                capture_r <= PWDATA[15:0];
            end
        end
    end

    // Control 0: capture flag is sticky, write one to clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl0_r <= `TCR_RST_CTRL;
        end else if (CE) begin
            if (wr_ctrl0) begin
                ctrl0_r[7:1] <= PWDATA[7:1];
            end
            if (cap_irq) begin
                ctrl0_r[`TCR_C0_CAPFLAG] <= 1'b1;
            end else if (wr_ctrl0 && PWDATA[`TCR_C0_CAPFLAG]) begin
                ctrl0_r[`TCR_C0_CAPFLAG] <= 1'b0;
            end
        end
    end

    // Control 1: a one-shot run disables itself at reload
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl1_r <= `TCR_RST_CTRL;
        end else if (CE) begin
            if (wr_ctrl1) begin
                ctrl1_r <= PWDATA[7:0];
            end else if (rel_ev && (mode == TCR_ONE_SHOT)) begin
                ctrl1_r[`TCR_C1_EN] <= 1'b0;
            end
        end
    end

    // Interrupt status, set wins over a clear in the same cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_st_r <= `TCR_RST_IRQ;
        end else if (CE) begin
            irq_st_r <= (irq_st_r & ~(wr_status ? PWDATA[1:0] : 2'h0)) |
                {rel_irq, cap_irq};
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_mask_r <= `TCR_RST_IRQ;
        end else if (CE && wr_mask) begin
            irq_mask_r <= PWDATA[1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            glb_r <= `TCR_RST_GLOBAL;
        end else if (CE && wr_global) begin
            glb_r <= PWDATA[1:0];
        end
    end

    // Output level: idle shows polarity, running toggles on reload
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            out_r <= 1'b0;
        end else if (CE) begin
            if (!en) begin
                out_r <= pol;
            end else if (rel_ev) begin
                out_r <= !out_r;
            end
        end
    end

    assign TOUT = out_r;
    assign TOUT_OE = glb_r[`TCR_GL_OUTEN];
    assign IRQ = glb_r[`TCR_GL_GLOBAL_IRQ_ENABLE] &&
        (|(irq_st_r & irq_mask_r));

    // Error flag is latched in the setup cycle, shown in the access phase
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pslverr_r <= 1'b0;
        end else if (CE && setup) begin
            pslverr_r <= !addr_known(PADDR);
        end
    end

    // Read data is latched in the setup cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            prdata_r <= 32'h0000_0000;
        end else if (CE && setup) begin
            case (PADDR)
                `TCR_OFS_CTRL0: prdata_r <= {24'h000000, ctrl0_r};
                `TCR_OFS_CTRL1: prdata_r <= {24'h000000, ctrl1_r};
                `TCR_OFS_COUNT: prdata_r <= {16'h0000, count_r};
                `TCR_OFS_RELOAD: prdata_r <= {16'h0000, reload_r};
                `TCR_OFS_CAPTURE: prdata_r <= {16'h0000, capture_r};
                `TCR_OFS_IRQ_STATUS: prdata_r <= {30'h0, irq_st_r};
                `TCR_OFS_IRQ_MASK: prdata_r <= {30'h0, irq_mask_r};
                `TCR_OFS_GLOBAL: prdata_r <= {30'h0, glb_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end
endmodule : tcr_timer
`default_nettype wire

// >>> hdl/tcr_defs.svh
// Register offsets, field positions, reset values and codes of the timer
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

`define TCR_OFS_CTRL0 8'h00
`define TCR_OFS_CTRL1 8'h04
`define TCR_OFS_COUNT 8'h08
`define TCR_OFS_RELOAD 8'h0C
`define TCR_OFS_CAPTURE 8'h10
`define TCR_OFS_IRQ_STATUS 8'h14
`define TCR_OFS_IRQ_MASK 8'h18
`define TCR_OFS_GLOBAL 8'h1C

`define TCR_C0_MODE_HI 7
`define TCR_C0_ISRC_HI 6
`define TCR_C0_ISRC_LO 5
`define TCR_C0_CAPFLAG 0
`define TCR_C1_EN 7
`define TCR_C1_POL 6
`define TCR_C1_PRESCALE_SELECT_HI 5
`define TCR_C1_PRESCALE_SELECT_LO 3
`define TCR_C1_MODE_HI 2
`define TCR_C1_MODE_LO 0
`define TCR_IRQ_CAP 0
`define TCR_IRQ_REL 1
`define TCR_GL_GLOBAL_IRQ_ENABLE 0
`define TCR_GL_OUTEN 1

`define TCR_RST_CTRL 8'h00
`define TCR_RST_COUNT 16'h0000
`define TCR_RST_RELOAD 16'hFFFF
`define TCR_RST_CAPTURE 16'h0000
`define TCR_RST_IRQ 2'h0
`define TCR_RST_GLOBAL 2'h0
`define TCR_RESTART 16'h0001

`define TCR_ISRC_CAP_ONLY 2'h2
`define TCR_ISRC_REL_ONLY 2'h3

`define TCR_MODE_ONE_SHOT 4'h0
`define TCR_MODE_CONTINUOUS 4'h1
`define TCR_MODE_COUNTER 4'h2
`define TCR_MODE_PWM_SINGLE 4'h3
`define TCR_MODE_CAPTURE 4'h4
`define TCR_MODE_COMPARE 4'h5
`define TCR_MODE_GATED 4'h6
`define TCR_MODE_CAP_CMP 4'h7
`define TCR_MODE_CAP_RESTART 4'h8
`define TCR_MODE_CMP_COUNTER 4'h9

`endif

// >>> hdl/tcr_pkg.sv
// Types and mode decoding shared by the timer modules
`default_nettype none
`include "tcr_defs.svh"
package tcr_pkg;
    typedef logic [7:0] tcr_addr_t;
    typedef logic [31:0] tcr_data_t;
    typedef logic [15:0] tcr_word_t;
    typedef logic [2:0] tcr_prescale_select_t;
    typedef enum {
        TCR_ONE_SHOT, TCR_CONTINUOUS, TCR_COUNTER, TCR_PWM_SINGLE,
        TCR_CAPTURE, TCR_COMPARE, TCR_GATED, TCR_CAP_CMP,
        TCR_CAP_RESTART, TCR_CMP_COUNTER, TCR_UNUSED
    } tcr_mode_t;

    function automatic tcr_mode_t tcr_mode_decode(input logic [3:0] code);
        case (code)
            `TCR_MODE_ONE_SHOT: return TCR_ONE_SHOT;
            `TCR_MODE_CONTINUOUS: return TCR_CONTINUOUS;
            `TCR_MODE_COUNTER: return TCR_COUNTER;
            `TCR_MODE_PWM_SINGLE: return TCR_PWM_SINGLE;
            `TCR_MODE_CAPTURE: return TCR_CAPTURE;
            `TCR_MODE_COMPARE: return TCR_COMPARE;
            `TCR_MODE_GATED: return TCR_GATED;
            `TCR_MODE_CAP_CMP: return TCR_CAP_CMP;
            `TCR_MODE_CAP_RESTART: return TCR_CAP_RESTART;
            `TCR_MODE_CMP_COUNTER: return TCR_CMP_COUNTER;
            default: return TCR_UNUSED;
        endcase
    endfunction : tcr_mode_decode
endpackage : tcr_pkg
`default_nettype wire

// >>> hdl/tcr_tick_if.sv
// Link between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface tcr_tick_if;
    logic run;
    logic [2:0] sel;
    logic tick;
    modport core (output run, output sel, input tick);
    modport pre (input run, input sel, output tick);
endinterface : tcr_tick_if
`default_nettype wire

// >>> hdl/tcr_prescaler.sv
// Power-of-two prescaler for the timer count
`timescale 1ns/1ps
`default_nettype none
module tcr_prescaler (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, high
    input wire logic ce, // Clock enable
    tcr_tick_if.pre tk // Run, divide select, tick
);
    import tcr_pkg::*;

    logic [6:0] div_r;

    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        return 7'((8'h01 << sel) - 8'h01);
    endfunction : div_mask

    // Held at zero while disabled so each start divides cleanly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 7'h00;
        end else if (ce) begin
            if (!tk.run) begin
                div_r <= 7'h00;
            end else begin
                div_r <= 7'(div_r + 7'h01);
            end
        end
    end

    // One tick every 2^sel cycles
    assign tk.tick = tk.run &&
        ((div_r & div_mask(tk.sel)) == div_mask(tk.sel));
endmodule : tcr_prescaler
`default_nettype wire

// >>> dv/tcr_src.sv
// Behavioural source for the timer input and comparator pins
`timescale 1ns/1ps
`default_nettype none
module tcr_src (
    input wire logic clk, // System clock
    output var logic tin, // Timer input level
    output var logic cmp // Comparator output level
);
    initial begin
        tin = 1'b0;
        cmp = 1'b0;
    end
    // Change after an edge, then hold so the synchroniser settles
    task automatic put_tin(input logic v, input int hold);
        @(posedge clk);
        tin <= v;
        repeat (hold) @(posedge clk);
    endtask : put_tin
    task automatic put_cmp(input logic v, input int hold);
        @(posedge clk);
        cmp <= v;
        repeat (hold) @(posedge clk);
    endtask : put_cmp
endmodule : tcr_src
`default_nettype wire

// >>> dv/tcr_timer_properties.sv
// Port-level assertions for the capture/restart timer
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"
module tcr_chk (
    input wire logic REF_CLK, // System clock
    input wire logic RST, // Reset, high
    input wire logic CE, // Clock enable
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access
    input wire logic PWRITE, // APB write
    input wire tcr_pkg::tcr_addr_t PADDR, // APB address
    input wire tcr_pkg::tcr_data_t PWDATA, // APB write data
    input wire logic PREADY, // APB ready
    input wire logic PSLVERR, // APB error
    input wire logic TIMER_IN, // Timer input pin
    input wire logic TOUT, // Timer output
    input wire logic TOUT_OE, // Output enable
    input wire logic IRQ // Interrupt
);
    import tcr_pkg::*;
    logic [7:0] c0_r, c1_r;
    logic [1:0] gl_r, mk_r;
    logic wr, unm;
    assign wr = PSEL && PENABLE && PWRITE && CE;
    assign unm = PADDR[7:5] != 3'h0 || PADDR[1:0] != 2'h0;
    // Shadow of the control registers written over APB
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
            gl_r <= 2'h0;
            mk_r <= 2'h0;
        end else if (wr) begin
            if (PADDR == `TCR_OFS_CTRL0) c0_r <= PWDATA[7:0];
            if (PADDR == `TCR_OFS_CTRL1) c1_r <= PWDATA[7:0];
            if (PADDR == `TCR_OFS_GLOBAL) gl_r <= PWDATA[1:0];
            if (PADDR == `TCR_OFS_IRQ_MASK) mk_r <= PWDATA[1:0];
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_ready_ce: assert property (PREADY == CE)
        else $error("ready does not follow clock enable");
    a_err_unmapped: assert property (PSEL && PENABLE && CE && unm |-> PSLVERR)
        else $error("no error on unmapped access");
    a_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
        else $error("error outside access phase");
    a_irq_gate: assert property (!gl_r[0] |-> !IRQ)
        else $error("interrupt with global enable off");
    a_irq_masked: assert property (mk_r == 2'h0 |-> !IRQ)
        else $error("interrupt with all sources masked");
    a_oe_follow: assert property (TOUT_OE == gl_r[1])
        else $error("output enable differs from pin function bit");
    a_out_idle: assert property (!c1_r[7] && !$past(c1_r[7])
        && $stable(c1_r[6]) |-> TOUT == c1_r[6])
        else $error("idle output differs from polarity");
    a_pol_hold: assert property (wr && PADDR == `TCR_OFS_CTRL1
        && c1_r[7] && PWDATA[7] && PWDATA[6] != c1_r[6]
        |=> $stable(TOUT) [*2])
        else $error("output moved on polarity change while running");
    a_cap_irq: assert property ($changed(TIMER_IN)
        && TIMER_IN != c1_r[6] && c1_r[7] && CE
        && {c0_r[7], c1_r[2:0]} == `TCR_MODE_CAP_RESTART
        && c0_r[6:5] != `TCR_ISRC_REL_ONLY && gl_r[0] && mk_r[0]
        |-> ##[1:8] IRQ)
        else $error("no interrupt after capture edge");
endmodule : tcr_chk
bind tcr_timer tcr_chk chk_u (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TIMER_IN(TIMER_IN), .TOUT(TOUT), .TOUT_OE(TOUT_OE), .IRQ(IRQ));
`default_nettype wire

// >>> dv/tb_timer_capture_restart.sv
// Self-checking testbench for the capture/restart timer
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"
module tb_timer_capture_restart;
    import tcr_pkg::*;
    logic clk, rst, ce, psel, pen, pwr;
    tcr_addr_t paddr;
    tcr_data_t pwdata, prdata, rd, k;
    logic pready, pslverr, tin, cmpi, tout, toe, irq, err;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    tcr_timer dut_u (.REF_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TIMER_IN(tin), .CMP_IN(cmpi), .TOUT(tout), .TOUT_OE(toe),
        .IRQ(irq));
    tcr_src src_u (.clk(clk), .tin(tin), .cmp(cmpi));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input tcr_data_t got, input tcr_data_t exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input tcr_data_t got, lo, hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_in
    // One APB transfer; st cycles of clock enable low in the access phase
    task automatic xfer(input logic w, tcr_addr_t a, tcr_data_t d, int st);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        if (st > 0) ce <= 1'b0;
        repeat (st) @(posedge clk);
        if (st > 0) ce <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task automatic wr(input tcr_addr_t a, input tcr_data_t d);
        xfer(1'b1, a, d, 0);
    endtask : wr
    task automatic rc(input tcr_addr_t a, input tcr_data_t exp);
        xfer(1'b0, a, 32'h0, 0);
        chk(rd, exp);
    endtask : rc
    task automatic cfg(input logic [7:0] c0, c1, input tcr_data_t rel,
        input logic [1:0] gl);
        wr(`TCR_OFS_CTRL1, 32'h0); // disable before setup
        wr(`TCR_OFS_CTRL0, {24'h0, c0 | 8'h01});
        wr(`TCR_OFS_CTRL1, {24'h0, c1});
        wr(`TCR_OFS_COUNT, 32'h1);
        wr(`TCR_OFS_RELOAD, rel);
        wr(`TCR_OFS_CAPTURE, 32'h0);
        wr(`TCR_OFS_IRQ_STATUS, 32'h3);
        wr(`TCR_OFS_IRQ_MASK, 32'h3);
        wr(`TCR_OFS_GLOBAL, {30'h0, gl});
        wr(`TCR_OFS_CTRL1, {24'h0, c1 | 8'h80});
        t0 = cyc;
    endtask : cfg
    task automatic stop_test();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rc(tcr_addr_t'(i * 4), i == 3 ? 32'(`TCR_RST_RELOAD) : 32'h0);
        xfer(1'b1, 8'h20, 32'hFFFFFFFF, 2);
        chk(err, 1);
        rc(8'h22, 32'h0);
        chk(err, 1);
        wr(`TCR_OFS_RELOAD, 32'hFFFF1234);
        rc(`TCR_OFS_RELOAD, 32'h1234);
        $display("test registers done");
        for (int p = 0; p < 8; p++) begin
            cfg(8'h00, 8'h01 | 8'(p << 3), 32'hFFFF, 2'h0);
            if (p > 2) repeat ((3 << (p - 1)) - 2) @(posedge clk);
            xfer(1'b0, `TCR_OFS_COUNT, 32'h0, 0);
            if (p > 2) chk(rd, 2);
            k = rd;
            repeat (253) @(posedge clk);
            xfer(1'b0, `TCR_OFS_COUNT, 32'h0, 0);
            chk(rd - k, 256 >> p);
        end
        $display("test prescaler done");
        for (int p = 0; p < 2; p++) begin
            src_u.put_tin(!p[0], 2);
            cfg(8'h80, {1'b0, p[0], 6'h0}, 32'hFFFF, 2'h3);
            src_u.put_tin(p[0], 20);
            rc(`TCR_OFS_IRQ_STATUS, 32'h0);
            src_u.put_tin(!p[0], 8);
            k = cyc - t0 - 8;
            xfer(1'b0, `TCR_OFS_CAPTURE, 32'h0, 0);
            chk_in(rd, k, k + 8);
            xfer(1'b0, `TCR_OFS_COUNT, 32'h0, 0);
            chk_in(rd, 1, 20);
            rc(`TCR_OFS_IRQ_STATUS, 32'h1);
            rc(`TCR_OFS_CTRL0, 32'h81);
            chk(irq, 1);
            wr(`TCR_OFS_IRQ_STATUS, 32'h1);
            wr(`TCR_OFS_CTRL0, 32'h81);
            #1;
            chk(irq, 0);
        end
        $display("test capture done");
        for (int i = 0; i < 3; i++) begin
            cfg(i == 0 ? 8'hC0 : i == 1 ? 8'hE0 : 8'h80, 8'h0, 32'h40, 2'h3);
            repeat (80) @(posedge clk);
            #1;
            chk(irq, i > 0);
            if (i == 0) begin
                src_u.put_tin(1'b1, 8);
                chk(irq, 1);
            end
            if (i == 2) begin
                rc(`TCR_OFS_IRQ_STATUS, 32'h2);
                rc(`TCR_OFS_CAPTURE, 32'h0);
                xfer(1'b0, `TCR_OFS_COUNT, 32'h0, 0);
                chk_in(rd, 1, 32'h40);
            end
        end
        $display("test reload done");
        cfg(8'h80, 8'h40, 32'hFFFF, 2'h2);
        src_u.put_tin(1'b0, 8);
        rc(`TCR_OFS_IRQ_STATUS, 32'h1);
        chk(irq, 0);
        wr(`TCR_OFS_GLOBAL, 32'h3);
        #1;
        chk(irq, 1);
        chk(toe, 1);
        wr(`TCR_OFS_CTRL1, 32'h80);
        repeat (3) @(posedge clk);
        chk(tout, 1);
        wr(`TCR_OFS_CTRL1, 32'h00);
        repeat (3) @(posedge clk);
        chk(tout, 0);
        $display("test output pin done");
        cfg(8'h00, 8'h00, 32'h8, 2'h3);
        repeat (20) @(posedge clk);
        rc(`TCR_OFS_CTRL1, 32'h0);
        rc(`TCR_OFS_IRQ_STATUS, 32'h2);
        $display("test one-shot done");
        cfg(8'h80, 8'h01, 32'h3, 2'h3);
        for (int i = 0; i < 3; i++) begin
            src_u.put_cmp(1'b1, 4);
            src_u.put_cmp(1'b0, 4);
        end
        rc(`TCR_OFS_COUNT, 32'h1);
        chk(tout, 1);
        $display("test comparator done");
        stop_test();
    end
endmodule : tb_timer_capture_restart
`default_nettype wire
